// File: inc/fcp_pkg.sv
// Shared constants and carrier types of the feature connector port
package fcp_pkg;

    // ------------------------------------------------------------
    // Clocking
    // ------------------------------------------------------------
    localparam int CORE_KHZ      = 100000;
    localparam int PIX_MAX_KHZ   = 37500;
    // Half period of the driven pixel clock, rounded up so the rate never exceeds the limit
    localparam int PCLK_HALF_CYC = (CORE_KHZ + 2 * PIX_MAX_KHZ - 1) / (2 * PIX_MAX_KHZ);
    localparam int PACE_W        = 4;

    // ------------------------------------------------------------
    // Widths, codes and reset values
    // ------------------------------------------------------------
    localparam int         PIX_W       = 16;
    localparam int         NARROW_W    = 8;
    localparam int         BUF_DEPTH   = 2;
    localparam logic [1:0] GP_SEL_CONN = 2'h0;
    localparam logic       OE_N_OFF    = 1'h1;
    localparam logic       ENF_N_OFF   = 1'h1;
    localparam logic       MEM64_RST   = 1'h1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic             hsync;
        logic             vsync;
        logic             blank;
        logic [PIX_W-1:0] pixels;
    } fcp_word_s;

    typedef struct packed {
        logic video;
        logic sync;
        logic clock;
    } fcp_dir_s;

    typedef struct packed {
        logic en;
        logic style;
        logic narrow;
        logic video;
    } fcp_lctl_s;

    typedef enum logic {
        PH_LOW  = 1'b0,
        PH_HIGH = 1'b1
    } fcp_phase_e;

endpackage : fcp_pkg

// File: rtl/fcp_sync2.sv
// Two flip-flop level synchroniser
`timescale 1ns/100ps
module fcp_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         reset_i,
    // Level in and out
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta <= '0;
            q_o  <= '0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule : fcp_sync2

// File: rtl/fcp_pair_buf.sv
// Small valid/ready buffer that absorbs a stalled drain
`timescale 1ns/100ps
module fcp_pair_buf #(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         reset_i,
    // Fill side
    input  wire logic [W-1:0] in_data_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    // Drain side
    output logic      [W-1:0] out_data_o,
    output logic              out_valid_o,
    input  wire logic         out_ready_i
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0]   FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic [AW:0]   next_count;
    logic          push;
    logic          pop;

    assign push       = in_valid_i && in_ready_o;
    assign pop        = out_valid_o && out_ready_i;
    assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    assign out_data_o = mem[rd_ptr];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_ptr      <= '0;
            rd_ptr      <= '0;
            count       <= '0;
            in_ready_o  <= 1'b0;
            out_valid_o <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + AW'(1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + AW'(1);
            end
            count       <= next_count;
            // Flags are registered so the fill side sees a clean ready
            in_ready_o  <= next_count != FULL_CNT;
            out_valid_o <= next_count != '0;
        end
    end
endmodule : fcp_pair_buf

// File: rtl/fcp_port.sv
// Feature connector port: pin directions, pixel paths and pixel clock pacing
`timescale 1ns/100ps
// How it works
// - Style bit 1 uses the local peripheral bus pin set.
// - Style bit 0 uses pins shared with the upper memory data lines.
// - Sync and clock selects both high drive syncs, blank and clock.
// - Video select high drives pixel data out; low takes pixel data in.
// - Sync select low takes syncs and blank in; high drives them.
// - Clock select low takes the clock in for capture; high drives it.
// - Strobe select 1 captures input pixels with the separate input clock.
// - Enabling the connector pulls the enable output low while the pin select field routes it to the connector.
// - Compatible style with connector enabled limits memory to 32 bits.
// - Connector pixel clock never exceeds 37.5 MHz.
// - Compatible style shares selects and all 16 pixel lines with upper memory lines.
// - Peripheral-bus style keeps the full 64-bit memory bus.
// - Peripheral-bus style on local bus gives an 8-bit pixel path.
// - Peripheral-bus style on PCI gives 16 bits, 8 also selectable.
module fcp_port
    import fcp_pkg::*;
(
    // Clocks and reset
    input  wire logic             core_clk_i,
    input  wire logic             reset_i,
    input  wire logic             link_clk_i,
    // Control bits
    input  wire logic             conn_enable_i,
    input  wire logic             style_select_i,
    input  wire logic [1:0]       gp_pin_select_field_i,
    input  wire logic             input_strobe_sel_i,
    input  wire logic             pci_mode_i,
    input  wire logic             narrow8_i,
    // Direction selects from the card
    input  wire logic             video_dir_select_i,
    input  wire logic             sync_dir_select_i,
    input  wire logic             clock_dir_select_i,
    input  wire logic             pixel_dir_select_lpb_i,
    input  wire logic             sync_dir_select_lpb_i,
    input  wire logic             clock_dir_select_lpb_i,
    // Pixel bus pins
    input  wire logic [PIX_W-1:0] shared_pixel_bus_i,
    input  wire logic [PIX_W-1:0] connector_pixel_bus_i,
    output logic      [PIX_W-1:0] pix_bus_o,
    output logic      [PIX_W-1:0] shared_pixel_bus_oe_n_o,
    output logic      [PIX_W-1:0] connector_pixel_bus_oe_n_o,
    // Sync and blank pins
    input  wire logic             hsync_i,
    input  wire logic             vsync_i,
    input  wire logic             blank_line_i,
    output logic                  hsync_o,
    output logic                  vsync_o,
    output logic                  blank_line_o,
    output logic                  sync_oe_n_o,
    // Pixel clock pin and capture clock choice
    output logic                  pixel_clock_line_o,
    output logic                  pixel_clock_line_oe_n_o,
    output logic                  strobe_from_input_clock_o,
    // Isolation and memory width
    output logic                  connector_enable_out_o,
    output logic                  mem_bus_64_o,
    output logic                  shared_upper_owned_o,
    // Outgoing pixel stream
    input  wire fcp_word_s        tx_word_i,
    input  wire logic             tx_valid_i,
    output logic                  tx_ready_o,
    // Incoming pixel stream
    output fcp_word_s             rx_word_o,
    output logic                  rx_valid_o
);
    // ------------------------------------------------------------
    // Control registers and direction selects
    // ------------------------------------------------------------
    logic              en_q;
    logic              style_q;
    logic              narrow_q;
    logic [5:0]        dir_pins;
    logic [5:0]        dir_pins_q;
    logic [2:0]        dir_q;
    fcp_dir_s          dir_s;
    logic              vid_out;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            en_q     <= 1'b0;
            style_q  <= 1'b0;
            narrow_q <= 1'b0;
        end else begin
            en_q     <= conn_enable_i;
            style_q  <= style_select_i;
            narrow_q <= style_select_i && (!pci_mode_i || narrow8_i);
        end
    end

    // Both pin sets cross first; a mux ahead of the flops could glitch into them
    assign dir_pins = {pixel_dir_select_lpb_i, sync_dir_select_lpb_i, clock_dir_select_lpb_i,
                       video_dir_select_i, sync_dir_select_i, clock_dir_select_i};

    fcp_sync2 #(.W(6)) u_dir_sync (
        .clk_i   (core_clk_i),
        .reset_i (reset_i),
        .d_i     (dir_pins),
        .q_o     (dir_pins_q)
    );

    assign dir_q = style_q ? dir_pins_q[5:3] : dir_pins_q[2:0];

    assign dir_s   = fcp_dir_s'(dir_q);
    assign vid_out = en_q && dir_s.video;

    // ------------------------------------------------------------
    // Output enables, isolation and memory width
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync_oe_n_o               <= OE_N_OFF;
            pixel_clock_line_oe_n_o   <= OE_N_OFF;
            connector_enable_out_o    <= ENF_N_OFF;
            mem_bus_64_o              <= MEM64_RST;
            shared_upper_owned_o      <= 1'b0;
            strobe_from_input_clock_o <= 1'b0;
        end else begin
            sync_oe_n_o               <= !(en_q && dir_s.sync);
            pixel_clock_line_oe_n_o   <= !(en_q && dir_s.clock);
            // Low only while the enable pin is routed to the connector
            connector_enable_out_o    <= !(en_q && gp_pin_select_field_i == GP_SEL_CONN);
            mem_bus_64_o              <= !(en_q && !style_q);
            shared_upper_owned_o      <= en_q && !style_q;
            strobe_from_input_clock_o <= input_strobe_sel_i;
        end
    end

    for (genvar i = 0; i < PIX_W; i++) begin : g_lane
        localparam logic LOW_LANE = (i < NARROW_W);
        always_ff @(posedge core_clk_i or posedge reset_i) begin
            if (reset_i) begin
                shared_pixel_bus_oe_n_o[i]    <= OE_N_OFF;
                connector_pixel_bus_oe_n_o[i] <= OE_N_OFF;
            end else begin
                shared_pixel_bus_oe_n_o[i]    <= !(vid_out && !style_q);
                connector_pixel_bus_oe_n_o[i] <=
                    !(vid_out && style_q && (LOW_LANE || !narrow_q));
            end
        end
    end

    // ------------------------------------------------------------
    // Outgoing pixels, paced by a divided core clock
    // ------------------------------------------------------------
    localparam logic [PACE_W-1:0] PACE_LAST = PACE_W'(PCLK_HALF_CYC - 1);

    logic [PACE_W-1:0] pace_cnt;
    logic              tick;
    logic              launch;
    fcp_phase_e        pace_q;
    fcp_word_s         buf_word;
    logic              buf_valid;
    logic              pop;
    fcp_word_s         drv_q;

    assign tick   = pace_cnt == PACE_LAST;
    assign launch = tick && pace_q == PH_HIGH;
    assign pop    = launch && buf_valid && vid_out;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pace_cnt <= '0;
        end else begin
            pace_cnt <= tick ? '0 : pace_cnt + PACE_W'(1);
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pace_q             <= PH_LOW;
            pixel_clock_line_o <= 1'b0;
        end else if (tick) begin
            unique case (pace_q)
                PH_LOW: begin
                    pace_q             <= PH_HIGH;
                    pixel_clock_line_o <= 1'b1;
                end
                PH_HIGH: begin
                    pace_q             <= PH_LOW;
                    pixel_clock_line_o <= 1'b0;
                end
            endcase
        end
    end

    // The buffer lets the sender run ahead while the pacer waits
    fcp_pair_buf #(
        .W     ($bits(fcp_word_s)),
        .DEPTH (BUF_DEPTH)
    ) u_tx_buf (
        .clk_i       (core_clk_i),
        .reset_i     (reset_i),
        .in_data_i   (tx_word_i),
        .in_valid_i  (tx_valid_i),
        .in_ready_o  (tx_ready_o),
        .out_data_o  (buf_word),
        .out_valid_o (buf_valid),
        .out_ready_i (pop)
    );

    // Words change on the falling clock edge so the card samples on the rise
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            drv_q <= '0;
        end else if (pop) begin
            drv_q <= buf_word;
        end
    end

    assign pix_bus_o    = drv_q.pixels;
    assign hsync_o      = drv_q.hsync;
    assign vsync_o      = drv_q.vsync;
    assign blank_line_o = drv_q.blank;

    // ------------------------------------------------------------
    // Incoming pixels, captured on the link clock
    // ------------------------------------------------------------
    // Pins are caught raw on every rising link edge and sorted on the core side, so a
    // link clock that stops never leaves stale control behind in its domain
    localparam int RAW_W = $bits(fcp_word_s) + PIX_W;

    logic [RAW_W-1:0] slot_l [2];
    logic [RAW_W-1:0] raw_c;
    fcp_word_s        pin_word;
    logic             tog_l;

    // Two slots alternate, so a word rests two link periods before reuse
    always_ff @(posedge link_clk_i or posedge reset_i) begin
        if (reset_i) begin
            slot_l[0] <= '0;
            slot_l[1] <= '0;
            tog_l     <= 1'b0;
        end else begin
            slot_l[tog_l] <= {hsync_i, vsync_i, blank_line_i,
                              connector_pixel_bus_i, shared_pixel_bus_i};
            tog_l         <= !tog_l;
        end
    end

    // ------------------------------------------------------------
    // Handing captured words to the core domain
    // ------------------------------------------------------------
    logic tog_s;
    logic tog_d;
    logic take;

    fcp_sync2 #(.W(1)) u_tog_sync (
        .clk_i   (core_clk_i),
        .reset_i (reset_i),
        .d_i     (tog_l),
        .q_o     (tog_s)
    );

    // The slot read here was filled a synchroniser delay ago and holds still
    assign raw_c = slot_l[!tog_s];
    assign take  = tog_s != tog_d && en_q && !dir_s.video;

    always_comb begin
        pin_word = fcp_word_s'(raw_c[RAW_W-1:PIX_W]);
        if (!style_q) begin
            pin_word.pixels = raw_c[PIX_W-1:0];
        end
        if (narrow_q) begin
            pin_word.pixels[PIX_W-1:NARROW_W] = '0;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tog_d      <= 1'b0;
            rx_valid_o <= 1'b0;
            rx_word_o  <= '0;
        end else begin
            tog_d      <= tog_s;
            rx_valid_o <= take;
            if (take) begin
                rx_word_o <= pin_word;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_enable_held;
        (conn_enable_i && gp_pin_select_field_i == GP_SEL_CONN) [*2];
    endsequence

    sequence s_clk_rise;
        $rose(pixel_clock_line_o);
    endsequence

    a_enable_low: assert property (s_enable_held |=> !connector_enable_out_o)
        else $error("connector enable output not low after enable");
    a_video_release: assert property ($fell(dir_s.video) |=>
        (&shared_pixel_bus_oe_n_o) && (&connector_pixel_bus_oe_n_o))
        else $error("pixel drivers still on after video select fell");
    a_sync_drive: assert property (!sync_oe_n_o |-> $past(en_q) && $past(dir_s.sync))
        else $error("sync group driven without sync select");
    a_clock_drive: assert property (!pixel_clock_line_oe_n_o |->
        $past(en_q) && $past(dir_s.clock))
        else $error("pixel clock driven without clock select");
    a_lpb_set: assert property (!(&connector_pixel_bus_oe_n_o) |-> $past(style_q))
        else $error("peripheral bus pins driven in compatible style");
    a_shared_set: assert property (!(&shared_pixel_bus_oe_n_o) |-> !$past(style_q))
        else $error("shared pins driven in peripheral bus style");
    a_mem_width: assert property ((en_q && !style_q) |=>
        !mem_bus_64_o && shared_upper_owned_o)
        else $error("memory bus not narrowed in compatible style");
    a_full_width: assert property (style_q |=> mem_bus_64_o)
        else $error("memory bus narrowed in peripheral bus style");
    a_narrow_lanes: assert property (narrow_q |=>
        &connector_pixel_bus_oe_n_o[PIX_W-1:NARROW_W])
        else $error("upper lanes driven in 8-bit mode");
    a_clk_gap: assert property (s_clk_rise |=> (!$rose(pixel_clock_line_o)) [*3])
        else $error("pixel clock faster than the limit");
    a_input_quiet: assert property (!dir_s.video |=>
        &shared_pixel_bus_oe_n_o && &connector_pixel_bus_oe_n_o)
        else $error("pixel drivers on while group is input");
    a_launch_word: assert property (pop |=> drv_q == $past(buf_word))
        else $error("launched word not placed on the bus");

endmodule : fcp_port

// File: sim/fcp_card_model.sv
// Card-side model of the feature connector: link clock and incoming pixel words
`timescale 1ns/100ps
module fcp_card_model
    import fcp_pkg::*;
(
    // Link pins driven by the card
    output logic      link_clk_o,
    output fcp_word_s drive_o
);
    // ------------------------------------------------------------
    // Link pacing
    // ------------------------------------------------------------
    // 64 ns period keeps the card clock well below the pixel rate limit
    localparam realtime HALF_NS = 32.0;

    initial begin
        link_clk_o = 1'b0;
        drive_o    = '0;
    end

    // One word per link period; the clock stands still outside a frame
    task automatic send_word(input fcp_word_s w);
        drive_o = w;
        #(HALF_NS) link_clk_o = 1'b1;
        #(HALF_NS) link_clk_o = 1'b0;
        // Released lines show the inverse, so a stale word never passes
        drive_o = ~w;
    endtask : send_word
endmodule : fcp_card_model

// File: sim/fcp_port_tb.sv
// Self-checking bench of the feature connector port
`timescale 1ns/100ps
module fcp_port_tb;
    import fcp_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam fcp_word_s W0 = 19'h51234;
    localparam fcp_word_s W1 = 19'h2abcd;
    logic             core_clk_i = 1'b0;
    logic             reset_i = 1'b1;
    logic             link_clk_i;
    logic             conn_enable_i = 1'b0, style_select_i = 1'b0, input_strobe_sel_i = 1'b0;
    logic             pci_mode_i = 1'b0, narrow8_i = 1'b0, tx_valid_i = 1'b0;
    logic [1:0]       gp_pin_select_field_i = 2'h0;
    logic             video_dir_select_i = 1'b0, sync_dir_select_i = 1'b0;
    logic             clock_dir_select_i = 1'b0, pixel_dir_select_lpb_i = 1'b0;
    logic             sync_dir_select_lpb_i = 1'b0, clock_dir_select_lpb_i = 1'b0;
    logic [PIX_W-1:0] pix_bus_o, shared_pixel_bus_oe_n_o, connector_pixel_bus_oe_n_o;
    logic [PIX_W-1:0] shared_pixel_bus_i, connector_pixel_bus_i;
    logic             hsync_o, vsync_o, blank_line_o, sync_oe_n_o, hsync_i, vsync_i;
    logic             blank_line_i, pixel_clock_line_o, pixel_clock_line_oe_n_o;
    logic             strobe_from_input_clock_o, connector_enable_out_o, mem_bus_64_o;
    logic             shared_upper_owned_o, tx_ready_o, rx_valid_o;
    fcp_word_s        tx_word_i = '0;
    fcp_word_s        rx_word_o, card_w;
    fcp_word_s        tx_seen[$], rx_seen[$];
    logic [18:0]      prev_out = '0;
    int               bad_count = 0;
    int               n_compared = 0;

    always #5 core_clk_i = ~core_clk_i;

    // ------------------------------------------------------------
    // Pins: each line carries whoever enables it
    // ------------------------------------------------------------
    assign shared_pixel_bus_i    = (pix_bus_o & ~shared_pixel_bus_oe_n_o)
                                 | (card_w.pixels & shared_pixel_bus_oe_n_o);
    assign connector_pixel_bus_i = (pix_bus_o & ~connector_pixel_bus_oe_n_o)
                                 | (card_w.pixels & connector_pixel_bus_oe_n_o);
    assign hsync_i      = sync_oe_n_o ? card_w.hsync : hsync_o;
    assign vsync_i      = sync_oe_n_o ? card_w.vsync : vsync_o;
    assign blank_line_i = sync_oe_n_o ? card_w.blank : blank_line_o;

    fcp_port u_dut (
        .core_clk_i, .reset_i, .link_clk_i, .conn_enable_i, .style_select_i,
        .gp_pin_select_field_i, .input_strobe_sel_i, .pci_mode_i, .narrow8_i,
        .video_dir_select_i, .sync_dir_select_i, .clock_dir_select_i,
        .pixel_dir_select_lpb_i, .sync_dir_select_lpb_i, .clock_dir_select_lpb_i,
        .shared_pixel_bus_i, .connector_pixel_bus_i, .pix_bus_o,
        .shared_pixel_bus_oe_n_o, .connector_pixel_bus_oe_n_o, .hsync_i, .vsync_i,
        .blank_line_i, .hsync_o, .vsync_o, .blank_line_o, .sync_oe_n_o,
        .pixel_clock_line_o, .pixel_clock_line_oe_n_o, .strobe_from_input_clock_o,
        .connector_enable_out_o, .mem_bus_64_o, .shared_upper_owned_o,
        .tx_word_i, .tx_valid_i, .tx_ready_o, .rx_word_o, .rx_valid_o
    );

    fcp_card_model u_card (
        .link_clk_o (link_clk_i),
        .drive_o    (card_w)
    );

    // Watch on the falling edge, where outputs have settled
    always @(negedge core_clk_i) begin
        if (!reset_i && {hsync_o, vsync_o, blank_line_o, pix_bus_o} !== prev_out) begin
            prev_out = {hsync_o, vsync_o, blank_line_o, pix_bus_o};
            tx_seen.push_back(prev_out);
        end
        if (rx_valid_o === 1'b1) begin
            rx_seen.push_back(rx_word_o);
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results;
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    task automatic set_ctl(input logic en, st, pci, nar, strb);
        @(posedge core_clk_i);
        {conn_enable_i, style_select_i, pci_mode_i, narrow8_i} <= {en, st, pci, nar};
        input_strobe_sel_i <= strb;
        repeat (6) @(negedge core_clk_i);
    endtask : set_ctl

    // Direction selects come from the card; both pin sets move together
    task automatic set_dir(input logic v, s, c);
        @(posedge core_clk_i);
        {video_dir_select_i, sync_dir_select_i, clock_dir_select_i} <= {v, s, c};
        {pixel_dir_select_lpb_i, sync_dir_select_lpb_i, clock_dir_select_lpb_i} <= {v, s, c};
        repeat (6) @(negedge core_clk_i);
    endtask : set_dir

    // Called just after a rising edge; returns at the edge that took the word
    task automatic push(input fcp_word_s w);
        int i;
        i = 0;
        tx_word_i  <= w;
        tx_valid_i <= 1'b1;
        @(negedge core_clk_i);
        while (tx_ready_o !== 1'b1) begin
            i++;
            if (i > 40) begin
                bad_count++;
                results();
            end
            @(negedge core_clk_i);
        end
        @(posedge core_clk_i);
    endtask : push

    task automatic clk_period;
        logic last;
        int   n;
        int   k;
        n = 0;
        k = 0;
        for (int i = 0; i < 40 && k < 2; i++) begin
            last = pixel_clock_line_o;
            @(negedge core_clk_i);
            if (k == 1) n++;
            if (last === 1'b0 && pixel_clock_line_o === 1'b1) k++;
        end
        check(n, 2 * PCLK_HALF_CYC);
    endtask : clk_period

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge core_clk_i);
        reset_i <= 1'b0;
        repeat (2) @(negedge core_clk_i);
        check({shared_pixel_bus_oe_n_o, connector_pixel_bus_oe_n_o}, 32'hffffffff);
        check({connector_enable_out_o, mem_bus_64_o, tx_ready_o}, 3'h7);
        $display("test reset done");

        for (int st = 0; st < 2; st++) begin
            set_ctl(1'b1, st[0], 1'b1, 1'b0, 1'b0);
            check(mem_bus_64_o, st[0]);
            check(shared_upper_owned_o, !st[0]);
            check(connector_enable_out_o, 1'h0);
            for (int i = 0; i < 8; i++) begin
                set_dir(i[2], i[1], i[0]);
                check(shared_pixel_bus_oe_n_o, st ? 16'hffff : {16{~i[2]}});
                check(connector_pixel_bus_oe_n_o, st ? {16{~i[2]}} : 16'hffff);
                check(sync_oe_n_o, !i[1]);
                check(pixel_clock_line_oe_n_o, !i[0]);
            end
        end
        set_ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        check(connector_pixel_bus_oe_n_o, 16'hff00);
        set_ctl(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
        check(connector_pixel_bus_oe_n_o, 16'hff00);
        set_ctl(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
        check({sync_oe_n_o, pixel_clock_line_oe_n_o, connector_pixel_bus_oe_n_o}, 18'h3ffff);
        check(connector_enable_out_o, 1'h1);
        $display("test directions done");

        set_ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        set_dir(1'b0, 1'b1, 1'b1);
        tx_seen.delete();
        @(posedge core_clk_i);
        push(W0);
        push(W1);
        tx_valid_i <= 1'b0;
        repeat (2) @(negedge core_clk_i);
        check(tx_ready_o, 1'h0);
        check(tx_seen.size(), 0);
        set_dir(1'b1, 1'b1, 1'b1);
        repeat (16) @(negedge core_clk_i);
        check(tx_ready_o, 1'h1);
        check(tx_seen.size(), 2);
        check(tx_seen[0], W0);
        check(tx_seen[1], W1);
        clk_period();
        @(posedge core_clk_i);
        gp_pin_select_field_i <= 2'h1;
        repeat (3) @(negedge core_clk_i);
        check(connector_enable_out_o, 1'h1);
        @(posedge core_clk_i);
        gp_pin_select_field_i <= 2'h0;
        $display("test transmit done");

        set_ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        set_dir(1'b0, 1'b0, 1'b0);
        check(strobe_from_input_clock_o, 1'h1);
        rx_seen.delete();
        #7;
        u_card.send_word(W0);
        u_card.send_word(W1);
        set_ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
        u_card.send_word(W1);
        set_ctl(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        check(strobe_from_input_clock_o, 1'h0);
        u_card.send_word(W0);
        repeat (10) @(negedge core_clk_i);
        check(rx_seen.size(), 4);
        check(rx_seen[0], W0);
        check(rx_seen[1], W1);
        check(rx_seen[2], 19'h200cd);
        check(rx_seen[3], W0);
        $display("test receive done");
        results();
    end
endmodule : fcp_port_tb
